// [src/sdg_pkg.sv]
// Shared constants, carriers and lookup tables of the signal-detect gate.
// Assumes a 100 MHz system clock and 24-bit signed post-volume samples.
package sdg_pkg;

	// Eight input channels of one fixed sample width.
	localparam int SDG_CH = 8;
	localparam int SDG_SW = 24;

	// One sample word.
	typedef logic [SDG_SW-1:0] sdg_smp_t;

	// One sample frame for all channels, qualified by one strobe.
	typedef struct packed {
		logic valid;
		logic [SDG_CH-1:0][SDG_SW-1:0] data;
	} sdg_frame_t;

	// Register indices; the byte address is four times the index.
	localparam logic [13:0] SDG_IDX_CTRL [SDG_CH] = '{
		14'h0312, 14'h0316, 14'h031a, 14'h031e,
		14'h0320, 14'h0326, 14'h032a, 14'h032e
	};
	localparam logic [13:0] SDG_IDX_GLB = 14'h0340;
	localparam logic [13:0] SDG_IDX_STAT = 14'h0350;
	localparam logic [13:0] SDG_IDX_MASK = 14'h0351;
	localparam logic [13:0] SDG_IDX_STATE = 14'h0352;

	// Field positions.
	localparam int SDG_EN_BIT = 15;
	localparam int SDG_THR_MSB = 8;
	localparam int SDG_THR_LSB = 4;
	localparam int SDG_HOLD_MSB = 3;
	localparam int SDG_HOLD_LSB = 0;

	// Values after reset.
	localparam logic [4:0] SDG_THR_RST = 5'h00;
	localparam logic [3:0] SDG_HOLD_RST = 4'h1;

	// Hold time is counted in ticks of this period.
	localparam int SDG_CLK_MHZ = 100;
	localparam int SDG_TICK_MS = 4;
	localparam int SDG_TICK_CYC = SDG_TICK_MS * 1000 * SDG_CLK_MHZ;
	localparam int SDG_TICK_W = 20;

	// Threshold code to magnitude on a 24-bit full scale; reserved codes act as the lowest level.
	function automatic sdg_smp_t sdg_thr_level(input logic [4:0] code);
		case (code)
			5'h00: sdg_thr_level = 24'h040000;
			5'h01: sdg_thr_level = 24'h020000;
			5'h02: sdg_thr_level = 24'h010000;
			5'h03: sdg_thr_level = 24'h008000;
			5'h04: sdg_thr_level = 24'h005f96;
			5'h05: sdg_thr_level = 24'h004000;
			5'h06: sdg_thr_level = 24'h002fe8;
			5'h07: sdg_thr_level = 24'h002000;
			5'h08: sdg_thr_level = 24'h001000;
			5'h09: sdg_thr_level = 24'h000bfa;
			5'h0a: sdg_thr_level = 24'h000800;
			5'h0b: sdg_thr_level = 24'h000608;
			5'h0c: sdg_thr_level = 24'h000400;
			default: sdg_thr_level = 24'h0002fd;
		endcase
	endfunction

	// Hold code to whole ticks; the upper codes are not linear, and reserved code 0 acts as code 1.
	function automatic logic [7:0] sdg_hold_ticks(input logic [3:0] code);
		case (code)
			4'h0: sdg_hold_ticks = 8'h01;
			4'hb: sdg_hold_ticks = 8'h0c;
			4'hc: sdg_hold_ticks = 8'h18;
			4'hd: sdg_hold_ticks = 8'h30;
			4'he: sdg_hold_ticks = 8'h60;
			4'hf: sdg_hold_ticks = 8'hc0;
			default: sdg_hold_ticks = {4'h0, code};
		endcase
	endfunction

endpackage

// [src/sdg_chan.sv]
// One channel of the signal-detect gate: level compare, hold timer, output gate.
// Assumes samples and the hold tick come from logic on sys_clk.
`timescale 1ns/1ps
module sdg_chan (
	input wire logic sys_clk, // System clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic det_en, // Detection enable of this channel.
	input wire sdg_pkg::sdg_smp_t thr_level, // Threshold magnitude.
	input wire logic [7:0] hold_ticks, // Hold time in ticks.
	input wire logic tick, // One-cycle hold tick.
	input wire logic in_valid, // Input sample strobe.
	input wire sdg_pkg::sdg_smp_t in_data, // Post-volume input sample.
	output logic out_valid, // Output sample strobe.
	output sdg_pkg::sdg_smp_t out_data, // Gated output sample.
	output logic detected // Channel is unmuted by detection.
);
	import sdg_pkg::*;

	sdg_smp_t mag; // Sample magnitude.
	logic is_above; // Sample exceeds the threshold.
	logic det_reg, det_next;
	logic above_reg, above_next;
	logic ov_reg, ov_next;
	sdg_smp_t od_reg, od_next;
	logic [7:0] cnt_reg, cnt_next; // Ticks spent below since the last loud sample.
	logic [8:0] since_reg, since_next; // Checker helper: ticks spent below the threshold.

	// Level is taken on the sample after mute and volume, so a muted path never detects.
	assign mag = in_data[SDG_SW-1] ? (~in_data + 1'b1) : in_data;
	assign is_above = mag > thr_level;

	// Detection state, hold count and the gated output.
	always_comb begin
		det_next = det_reg;
		above_next = above_reg;
		cnt_next = cnt_reg;
		if (!det_en) begin
			det_next = 1'b0;
			above_next = 1'b0;
			cnt_next = 8'h00;
		end else if (in_valid && is_above) begin
			// Unmute on this very sample and restart the hold time.
			det_next = 1'b1;
			above_next = 1'b1;
			cnt_next = 8'h00;
		end else begin
			if (in_valid) begin
				above_next = 1'b0;
			end
			if (det_reg && !above_next && tick) begin
				// The compare is >= so a hold code changed mid-count cannot be skipped.
				if (cnt_reg >= hold_ticks) begin
					det_next = 1'b0;
					cnt_next = 8'h00;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
		end
		ov_next = in_valid;
		od_next = od_reg;
		if (in_valid) begin
			od_next = (det_en && !det_next) ? '0 : in_data;
		end
	end

	// Register the channel state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			det_reg <= 1'b0;
			above_reg <= 1'b0;
			cnt_reg <= 8'h00;
			ov_reg <= 1'b0;
			od_reg <= '0;
		end else begin
			det_reg <= det_next;
			above_reg <= above_next;
			cnt_reg <= cnt_next;
			ov_reg <= ov_next;
			od_reg <= od_next;
		end
	end

	// Checker helper, counted independently of the hold logic.
	always_comb begin
		since_next = since_reg;
		// Time below starts at the first quiet sample, so a loud sample that still stands keeps it at zero.
		if (!det_en || (in_valid ? is_above : above_reg)) begin
			since_next = 9'h000;
		end else if (tick && !since_reg[8]) begin
			since_next = since_reg + 9'h001;
		end
	end

	// Register the helper.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			since_reg <= 9'h000;
		end else begin
			since_reg <= since_next;
		end
	end

	assign out_valid = ov_reg;
	assign out_data = od_reg;
	assign detected = det_reg;

	chk_unmute_now: assert property (@(posedge sys_clk) disable iff (rst)
		det_en && in_valid && is_above |=> det_reg && od_reg == $past(in_data))
		else $error("loud sample did not unmute at once");
	chk_muted_zero: assert property (@(posedge sys_clk) disable iff (rst)
		ov_reg && $past(det_en) && !det_reg |-> od_reg == '0)
		else $error("muted channel passed a nonzero sample");
	chk_disabled_pass: assert property (@(posedge sys_clk) disable iff (rst)
		in_valid && !det_en |=> !det_reg && od_reg == $past(in_data))
		else $error("disabled channel gated or detected");
	chk_hold_min: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(det_reg) && det_en && $past(det_en) |-> since_reg > {1'b0, $past(hold_ticks)})
		else $error("mute applied before hold time ran out");
	chk_hold_max: assert property (@(posedge sys_clk) disable iff (rst)
		det_en && $past(det_en) && $stable(hold_ticks) && since_reg > {1'b0, hold_ticks} + 9'h001
		|-> !det_reg)
		else $error("mute late after hold time");
	chk_hold_restart: assert property (@(posedge sys_clk) disable iff (rst)
		det_en && det_reg && in_valid && is_above |=> cnt_reg == 8'h00 && det_reg)
		else $error("hold count not restarted");
endmodule

// [src/sdg_top.sv]
// Signal-detect gate for eight input channels with APB registers and one interrupt.
// Assumes frames arrive on sys_clk after the volume stage and APB runs on sys_clk.
// Assumes software keeps each watched path enabled and unmuted upstream, at a low sample rate.
// Limitation: the hold tick runs free, so every hold time has a spread of one tick.
`timescale 1ns/1ps
module sdg_top #(
	parameter int TICK_CYCLES = sdg_pkg::SDG_TICK_CYC // Cycles per hold tick.
) (
	input wire logic sys_clk, // System clock, 100 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB write direction.
	input wire logic [15:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB write byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire sdg_pkg::sdg_frame_t in_frame, // Post-volume input frame.
	output sdg_pkg::sdg_frame_t out_frame, // Gated output frame.
	output logic irq // Level interrupt.
);
	import sdg_pkg::*;

	// Control and status state.
	logic [SDG_CH-1:0] en_reg, en_next; // Detect enables.
	logic [4:0] thr_reg, thr_next; // Threshold code.
	logic [3:0] hold_reg, hold_next; // Hold code.
	logic stat_reg, stat_next; // Sticky detect event.
	logic mask_reg, mask_next; // Interrupt enable for the event.
	logic arm_reg, arm_next; // Event may fire again.
	logic irq_reg, irq_next;

	// Bus response state.
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;

	// Hold tick prescaler.
	logic [SDG_TICK_W-1:0] tcnt_reg, tcnt_next;
	logic tick_reg, tick_next;

	// Decode results and channel wires.
	logic [13:0] idx; // Word index of the current address.
	logic hit; // Address maps to a register.
	logic [31:0] rd_val; // Read value of the addressed register.
	logic setup; // APB setup cycle.
	logic done; // APB access completes at this edge.
	logic wr_ok; // Write takes effect at this edge.
	logic rd_stat; // Status read completes at this edge.
	logic ev; // Detect event of this cycle.
	logic any_det; // Any channel unmuted by detection.
	sdg_smp_t thr_level; // Threshold magnitude.
	logic [7:0] hold_ticks; // Hold in ticks.
	logic [SDG_CH-1:0] det_w; // Per-channel detect flags.
	logic [SDG_CH-1:0] ov_w; // Per-channel output strobes.
	logic [SDG_CH-1:0][SDG_SW-1:0] od_w; // Per-channel gated samples.

	assign idx = paddr[15:2];
	assign setup = psel && !penable;
	assign done = psel && penable && pready_reg;
	assign wr_ok = done && pwrite && !pslverr_reg;
	assign rd_stat = done && !pwrite && !pslverr_reg && paddr[1:0] == 2'h0 && idx == SDG_IDX_STAT;

	// One threshold and one hold time serve every channel.
	assign thr_level = sdg_thr_level(thr_reg);
	assign hold_ticks = sdg_hold_ticks(hold_reg);

	// Address decode and read mux; registers sit in the low 16 bits.
	always_comb begin
		hit = 1'b0;
		rd_val = 32'h00000000;
		// Misaligned addresses map to nothing and answer with an error.
		if (paddr[1:0] != 2'h0) begin
			hit = 1'b0;
		end else if (idx == SDG_IDX_GLB) begin
			hit = 1'b1;
			rd_val[SDG_THR_MSB:SDG_THR_LSB] = thr_reg;
			rd_val[SDG_HOLD_MSB:SDG_HOLD_LSB] = hold_reg;
		end else if (idx == SDG_IDX_STAT) begin
			hit = 1'b1;
			rd_val[0] = stat_reg;
		end else if (idx == SDG_IDX_MASK) begin
			hit = 1'b1;
			rd_val[0] = mask_reg;
		end else if (idx == SDG_IDX_STATE) begin
			hit = 1'b1;
			rd_val[SDG_CH-1:0] = det_w;
			rd_val[SDG_CH] = arm_reg;
		end else begin
			// The channel controls are scattered, so they are matched one by one.
			for (int i = 0; i < SDG_CH; i++) begin
				if (idx == SDG_IDX_CTRL[i]) begin
					hit = 1'b1;
					rd_val[SDG_EN_BIT] = en_reg[i];
				end
			end
		end
	end

	// Zero-wait-state slave: the answer is prepared in setup and shown in access.
	always_comb begin
		pready_next = setup;
		pslverr_next = setup && !hit;
		prdata_next = prdata_reg;
		// Read data is captured in setup, so a status read returns the value before its own clear.
		if (setup) begin
			prdata_next = pwrite ? 32'h00000000 : rd_val;
		end
	end

	// Register writes, honouring byte strobes of the low two lanes.
	always_comb begin
		en_next = en_reg;
		thr_next = thr_reg;
		hold_next = hold_reg;
		mask_next = mask_reg;
		// A refused access never reaches the registers.
		if (wr_ok && paddr[1:0] == 2'h0) begin
			if (idx == SDG_IDX_GLB) begin
				// The threshold field straddles the two low byte lanes, so each lane writes its own part.
				if (pstrb[1]) begin
					thr_next[4] = pwdata[SDG_THR_MSB];
				end
				if (pstrb[0]) begin
					thr_next[3:0] = pwdata[SDG_THR_MSB-1:SDG_THR_LSB];
					hold_next = pwdata[SDG_HOLD_MSB:SDG_HOLD_LSB];
				end
			end else if (idx == SDG_IDX_MASK) begin
				if (pstrb[0]) begin
					mask_next = pwdata[0];
				end
			end else begin
				for (int i = 0; i < SDG_CH; i++) begin
					if (idx == SDG_IDX_CTRL[i] && pstrb[1]) begin
						en_next[i] = pwdata[SDG_EN_BIT];
					end
				end
			end
		end
	end

	// Detect event, re-arm and sticky status; a new event wins over a read clear.
	always_comb begin
		any_det = |det_w;
		ev = arm_reg && any_det;
		arm_next = arm_reg;
		if (ev) begin
			arm_next = 1'b0;
		end else if (!any_det) begin
			// Waiting for every channel to go quiet keeps one burst to one interrupt.
			arm_next = 1'b1;
		end
		stat_next = stat_reg;
		// Only a bit that the reader actually saw is cleared, so an event in flight is not lost.
		if (rd_stat && prdata_reg[0]) begin
			stat_next = 1'b0;
		end
		// Placed after the clear, so an event in the clearing cycle wins.
		if (ev) begin
			stat_next = 1'b1;
		end
		irq_next = stat_next && mask_next;
	end

	// Hold tick prescaler; the tick phase gives the documented 4 ms spread.
	always_comb begin
		tick_next = 1'b0;
		tcnt_next = tcnt_reg + 1'b1;
		// One shared prescaler saves a counter per channel at the cost of the tick spread.
		if (tcnt_reg == SDG_TICK_W'(TICK_CYCLES - 1)) begin
			tcnt_next = '0;
			tick_next = 1'b1;
		end
	end

	// Register all top-level state.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			en_reg <= '0;
			thr_reg <= SDG_THR_RST;
			hold_reg <= SDG_HOLD_RST;
			stat_reg <= 1'b0;
			mask_reg <= 1'b0;
			// Armed from reset, so the first detection after reset is reported.
			arm_reg <= 1'b1;
			irq_reg <= 1'b0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			tcnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			en_reg <= en_next;
			thr_reg <= thr_next;
			hold_reg <= hold_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			arm_reg <= arm_next;
			irq_reg <= irq_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
			tcnt_reg <= tcnt_next;
			tick_reg <= tick_next;
		end
	end

	// One detector per channel.
	// Each channel keeps its own hold count, but all share the tick and the table lookups.
	for (genvar g = 0; g < SDG_CH; g++) begin : g_ch
		sdg_chan u_chan (
			.sys_clk(sys_clk),
			.rst(rst),
			.det_en(en_reg[g]),
			.thr_level(thr_level),
			.hold_ticks(hold_ticks),
			.tick(tick_reg),
			.in_valid(in_frame.valid),
			.in_data(in_frame.data[g]),
			.out_valid(ov_w[g]),
			.out_data(od_w[g]),
			.detected(det_w[g])
		);
	end

	// All channels share one strobe, so channel 0 stands for the frame.
	assign out_frame.valid = ov_w[0];
	assign out_frame.data = od_w;
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign irq = irq_reg;

	// Checks of the event, bus and hold logic; all but chk_hold_reset are disabled while reset is high.
	// Each check names the rule that it guards where there is one.
	chk_event_or: assert property (@(posedge sys_clk) disable iff (rst)
		arm_reg && $rose(det_w[SDG_CH-1]) |=> stat_reg && !arm_reg)
		else $error("channel detect did not raise the event");
	chk_event_armed: assert property (@(posedge sys_clk) disable iff (rst)
		!arm_reg && any_det |=> !arm_reg && !$rose(stat_reg))
		else $error("event re-armed while a channel detects");
	chk_irq_mask: assert property (@(posedge sys_clk) disable iff (rst)
		ev && mask_reg && !wr_ok |=> irq_reg ##1 (irq_reg || !stat_reg || !mask_reg))
		else $error("unmasked event did not raise irq");
	chk_apb_answer: assert property (@(posedge sys_clk) disable iff (rst)
		setup |=> pready_reg && pslverr_reg == !$past(hit) ##1 !pready_reg)
		else $error("apb answer not one cycle after setup");
	chk_hold_reset: assert property (@(posedge sys_clk)
		$past(rst) && !rst |-> hold_reg == SDG_HOLD_RST && hold_ticks == 8'h01)
		else $error("hold code not reset to one");

	// The interrupt pin is exactly the registered status gated by its mask.
	chk_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
		irq_reg == (stat_reg && mask_reg))
		else $error("irq does not follow status and mask");

	// A refused write leaves every register as it was.
	chk_err_no_write: assert property (@(posedge sys_clk) disable iff (rst)
		done && pwrite && pslverr_reg
		|=> $stable(en_reg) && $stable(thr_reg) && $stable(hold_reg) && $stable(mask_reg))
		else $error("refused write changed a register");

	// Every input frame leaves one cycle later, whatever the gating.
	chk_out_strobe: assert property (@(posedge sys_clk) disable iff (rst)
		in_frame.valid |=> out_frame.valid)
		else $error("output frame strobe missing");

	// The hold tick is a single-cycle pulse at the prescaler wrap.
	chk_tick_single: assert property (@(posedge sys_clk) disable iff (rst)
		tick_reg |=> !tick_reg)
		else $error("hold tick longer than one cycle");

	// The tick and the wrapped prescaler always line up.
	chk_tick_phase: assert property (@(posedge sys_clk) disable iff (rst)
		tick_reg |-> tcnt_reg == '0)
		else $error("hold tick out of phase with prescaler");

	// With no channel detecting, the event is armed again at the next edge.
	chk_rearm_quiet: assert property (@(posedge sys_clk) disable iff (rst)
		!any_det |=> arm_reg)
		else $error("event not re-armed after all channels went quiet");

	// A status read clears the bit it returned, unless a new event arrives.
	chk_clear_on_read: assert property (@(posedge sys_clk) disable iff (rst)
		rd_stat && prdata_reg[0] && !ev |=> !stat_reg)
		else $error("status not cleared by its read");
endmodule

// [test/sdg_vol_model.sv]
// Behavioural model of the post-volume input stage that feeds the gate.
// Assumes the bench calls send once per sample and nothing else drives the frame.
`timescale 1ns/1ps
module sdg_vol_model (
	input wire logic sys_clk, // System clock.
	output sdg_pkg::sdg_frame_t frame // Post-volume frame towards the gate.
);
	import sdg_pkg::*;

	// Start idle, so the gate sees no strobe before the first sample.
	initial begin
		frame = '0;
	end

	// Present one frame for one cycle.
	// Volume sits at unity and unmuted, so the sample reaches the gate as given.
	// Back-to-back calls send a frame every second cycle, far faster than an audio rate.
	task automatic send(input sdg_smp_t s);
		@(posedge sys_clk);
		frame.valid <= 1'b1;
		frame.data <= {SDG_CH{s}};
		@(posedge sys_clk);
		frame.valid <= 1'b0;
		// Stale data is inverted, so an old sample is never taken for a new one.
		frame.data <= ~{SDG_CH{s}};
	endtask
endmodule

// [test/test_sdg_top.sv]
// Self-checking bench of the signal-detect gate: APB register access, gating and interrupt.
// Assumes the gate and the input stage model both run on sys_clk.
`timescale 1ns/1ps
module test_sdg_top;
	import sdg_pkg::*;

	localparam int T = 20; // Shortened hold tick, in cycles.
	localparam sdg_smp_t Q = 24'h000123; // Quiet sample, below every threshold.
	localparam sdg_smp_t L = 24'h040001; // One step above threshold code 0.

	logic sys_clk = 1'b0; // Clock.
	logic rst = 1'b1; // Reset.
	logic psel = 1'b0; // APB select.
	logic penable = 1'b0; // APB enable.
	logic pwrite = 1'b0; // APB direction.
	logic [15:0] paddr = 16'h0000; // APB address.
	logic [31:0] pwdata = 32'h00000000; // APB write data.
	logic [31:0] prdata; // APB read data.
	logic pready; // APB ready.
	logic pslverr; // APB error.
	logic irq; // Interrupt level.
	sdg_frame_t in_frame; // Frame into the gate.
	sdg_frame_t out_frame; // Frame out of the gate.
	int num_errors = 0; // Mismatches seen.
	int checks_done = 0; // Comparisons made.
	logic [31:0] rd; // Data of the last read.
	logic err; // Error flag of the last access.

	// Free-running 100 MHz clock.
	always #5 sys_clk = ~sys_clk;

	sdg_vol_model i_sdg_vol_model (
		.sys_clk(sys_clk),
		.frame(in_frame)
	);

	sdg_top #(.TICK_CYCLES(T)) i_sdg_top (
		.sys_clk(sys_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(4'hf),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.in_frame(in_frame),
		.out_frame(out_frame),
		.irq(irq)
	);

	// Compare one value and count it.
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (n >= 50) begin
			chk("pready", pready, 32'h1);
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Read one register and compare its data.
	task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h00000000);
		chk("read data", rd, exp);
	endtask

	// Send one sample on every channel; channels 0 and 7 are gated, channel 3 stays disabled.
	task automatic frm(input sdg_smp_t s, input sdg_smp_t e);
		i_sdg_vol_model.send(s);
		#1;
		chk("out valid", out_frame.valid, 32'h1);
		chk("gated ch0", out_frame.data[0], e);
		chk("gated ch7", out_frame.data[7], e);
		chk("open ch3", out_frame.data[3], s);
	endtask

	// The hold starts at the first quiet sample: a quiet sample still passes just before it runs out.
	// A quiet sample well after it is zeroed.
	task automatic hold_chk(input logic [3:0] code, input int h);
		apb(1'b1, SDG_IDX_GLB, {28'h0000000, code});
		frm(L, L);
		frm(Q, Q);
		repeat (h * T - 8) @(posedge sys_clk);
		frm(Q, Q);
		repeat (2 * T + 4) @(posedge sys_clk);
		frm(Q, 24'h000000);
	endtask

	// Print the verdict and end the run.
	task automatic summarize();
		if (num_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Cut a hang short; the tests need far fewer cycles than this.
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		summarize();
	end

	// Main sequence.
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rdchk(SDG_IDX_GLB, 32'h00000001);
		rdchk(SDG_IDX_CTRL[0], 32'h00000000);
		apb(1'b0, 14'h0300, 32'h00000000);
		chk("unmapped error", err, 32'h1);
		apb(1'b1, 14'h0300, 32'h0000ffff);
		chk("unmapped write error", err, 32'h1);
		apb(1'b1, SDG_IDX_MASK, 32'h00000001);
		apb(1'b1, SDG_IDX_CTRL[0], 32'h00008000);
		apb(1'b1, SDG_IDX_CTRL[7], 32'h00008000);
		rdchk(SDG_IDX_CTRL[7], 32'h00008000);
		frm(Q, 24'h000000);
		frm(24'h040000, 24'h000000);
		frm(24'hfbffff, 24'hfbffff);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("irq", irq, 32'h1);
		rdchk(SDG_IDX_STAT, 32'h00000001);
		#1;
		chk("irq", irq, 32'h0);
		// A second loud sample while channels are still unmuted must not raise a new event.
		frm(L, L);
		repeat (3) @(posedge sys_clk);
		rdchk(SDG_IDX_STAT, 32'h00000000);
		frm(Q, Q);
		repeat (3 * T) @(posedge sys_clk);
		frm(Q, 24'h000000);
		frm(L, L);
		repeat (3) @(posedge sys_clk);
		rdchk(SDG_IDX_STAT, 32'h00000001);
		// Quiet spells shorter than the hold, each ended by a loud sample, keep the channel open.
		repeat (3) begin
			frm(Q, Q);
			repeat (12) @(posedge sys_clk);
			frm(Q, Q);
			frm(L, L);
		end
		repeat (14) @(posedge sys_clk);
		frm(Q, Q);
		hold_chk(4'h1, 1);
		hold_chk(4'h5, 5);
		hold_chk(4'hb, 12);
		hold_chk(4'hf, 192);
		// Lowest threshold: equal is quiet, one step above is loud.
		apb(1'b1, SDG_IDX_GLB, 32'h000000d1);
		frm(24'h0002fd, 24'h000000);
		frm(24'h0002fe, 24'h0002fe);
		summarize();
	end
endmodule
